// ===== bench/sprd_detect_properties.sv
/* Port checker for the pin-pattern reset detector.
   Assumes clock_enable held high and a 125 MHz system clock. */
module sprd_detect_properties
    import sprd_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic clock_enable,
    input  wire logic sel_clock,
    input  wire logic select_n,
    input  wire logic serial_clock,
    input  wire logic serial_in,
    input  wire logic udpd_request,
    input  wire logic device_reset,
    input  wire logic in_udpd,
    input  wire logic standby,
    input  wire logic command_enable,
    input  wire logic out_allowed,
    input  wire logic iface_awake
);
    // ------------------------------------------------------------------
    // Properties, all in the system domain
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    pulse_len_a: assert property (
        $rose(device_reset) |-> device_reset[*8] ##1 !device_reset)
        else $error("reset pulse length wrong");
    udpd_exit_a: assert property (
        $rose(device_reset) |-> ##[0:2] !in_udpd)
        else $error("deep sleep kept after reset");
    quiet_udpd_a: assert property (
        in_udpd |-> !command_enable && !out_allowed)
        else $error("commands open in deep sleep");
    reset_state_a: assert property (
        device_reset |-> !standby && !command_enable)
        else $error("state not cleared by reset");
    late_reset_a: assert property (
        $rose(device_reset) |-> select_n && $past(select_n, 3))
        else $error("reset before last pulse ended");
    out_gate_a: assert property (
        select_n[*6] |-> !out_allowed)
        else $error("output allowed while deselected");
    awake_sel_a: assert property (
        (!select_n)[*6] |-> iface_awake)
        else $error("interface not woken by select");
    wake_delay_a: assert property (
        $fell(device_reset) |-> (!standby)[*8])
        else $error("standby too soon after reset");
endmodule : sprd_detect_properties

bind sprd_detect sprd_detect_properties u_props (
    .clock(clock), .rst(rst), .clock_enable(clock_enable),
    .sel_clock(sel_clock), .select_n(select_n),
    .serial_clock(serial_clock), .serial_in(serial_in),
    .udpd_request(udpd_request), .device_reset(device_reset),
    .in_udpd(in_udpd), .standby(standby),
    .command_enable(command_enable), .out_allowed(out_allowed),
    .iface_awake(iface_awake));

// ===== bench/sprd_detect_tb_top.sv
/* Self-checking bench for the pin-pattern reset detector.
   Assumes sprd_pkg, the host model and the checker are compiled first. */
module sprd_detect_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sprd_pkg::*;

    logic clock = 1'b0;
    logic lclk  = 1'b0;
    logic rst   = 1'b1;
    logic udpd_request = 1'b0;
    logic select_n, serial_clock, serial_in;
    logic device_reset, in_udpd, standby, command_enable;
    logic out_allowed, iface_awake;
    int   err_count = 0;
    int   n_checks  = 0;

    // ------------------------------------------------------------------
    // Clocks: link timing is unrelated in phase to the system clock
    // ------------------------------------------------------------------
    initial forever #4 clock = ~clock;
    initial begin
        #3.3;
        forever #6 lclk = ~lclk;
    end

    sprd_host u_host (.lclk(lclk), .select_n(select_n),
        .serial_clock(serial_clock), .serial_in(serial_in));

    // Link clock is the select pin itself: it rises on the deselect edge
    sprd_detect DUT (.clock(clock), .rst(rst), .clock_enable(1'b1),
        .sel_clock(select_n), .select_n(select_n),
        .serial_clock(serial_clock), .serial_in(serial_in),
        .udpd_request(udpd_request), .device_reset(device_reset),
        .in_udpd(in_udpd), .standby(standby),
        .command_enable(command_enable), .out_allowed(out_allowed),
        .iface_awake(iface_awake));

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic seen,
                         input logic exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %b seen %b", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Pattern plus 40 cycles: long enough for sync and the whole pulse
    task automatic pattern(input logic [3:0] p, input logic g,
                           input logic exp);
        logic hit;
        hit = 1'b0;
        u_host.send(p, g);
        repeat (40) begin
            @(posedge clock);
            #1;
            if (device_reset === 1'b1) hit = 1'b1;
        end
        check("device_reset", hit, exp);
    endtask : pattern

    // Commands wait for standby, which must not come early
    task automatic to_standby;
        int n;
        n = 0;
        while (standby !== 1'b1 && n < 9500) begin
            @(posedge clock);
            #1;
            n++;
        end
        check("standby", standby, 1'b1);
        check("wake_time", n >= WAKE_CYCLES - 50, 1'b1);
    endtask : to_standby

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_power_up;
        repeat (20) @(posedge clock);
        #1;
        check("reset_level", device_reset, 1'b1);
        check("standby", standby, 1'b0);
        @(posedge clock);
        rst <= 1'b0;
        to_standby();
    endtask : test_power_up

    task automatic test_udpd_exit;
        @(posedge clock);
        udpd_request <= 1'b1;
        @(posedge clock);
        udpd_request <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        check("in_udpd", in_udpd, 1'b1);
        check("command_enable", command_enable, 1'b0);
        pattern(4'h5, 1'b0, 1'b1);
        check("in_udpd", in_udpd, 1'b0);
        to_standby();
    endtask : test_udpd_exit

    // Abort and mismatch, each followed by a good pattern
    task automatic test_refused;
        pattern(4'h5, 1'b1, 1'b0);
        pattern(4'h5, 1'b0, 1'b1);
        to_standby();
        pattern(4'hA, 1'b0, 1'b0);
        pattern(4'h5, 1'b0, 1'b1);
        to_standby();
    endtask : test_refused

    task automatic test_out;
        u_host.drive(1'b0, 1'b0, 1'b0);
        repeat (10) @(posedge clock);
        #1;
        check("iface_awake", iface_awake, 1'b1);
        check("out_allowed", out_allowed, 1'b0);
        u_host.drive(1'b0, 1'b1, 1'b0);
        repeat (10) @(posedge clock);
        #1;
        check("out_allowed", out_allowed, 1'b1);
        u_host.drive(1'b1, 1'b0, 1'b1);
    endtask : test_out

    // Watchdog: the run needs about 38000 cycles
    initial begin
        repeat (80000) @(posedge clock);
        err_count++;
        give_verdict();
    end

    initial begin
        test_power_up();
        test_udpd_exit();
        test_refused();
        test_out();
        give_verdict();
    end
endmodule : sprd_detect_tb_top

// ===== bench/sprd_host.sv
/* Host model driving the select, serial clock and data pins.
   Assumes a free link timing clock from the bench; pins move on it. */
module sprd_host (
    input  wire logic lclk,
    output logic      select_n,
    output logic      serial_clock,
    output logic      serial_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle: deselected, mode 0 clock low
    initial begin
        select_n     = 1'b1;
        serial_clock = 1'b0;
        serial_in    = 1'b1;
    end

    // One pin update per link clock rising edge
    task automatic drive(input logic s, input logic k, input logic d);
        @(posedge lclk);
        select_n     <= s;
        serial_clock <= k;
        serial_in    <= d;
    endtask : drive

    // Pattern MSB first; glitch adds one clock pulse in the fourth frame,
    // so the abort also leaves the pulse count aligned for the next send
    task automatic send(input logic [3:0] pat, input logic glitch);
        for (int i = 3; i >= 0; i--) begin
            drive(1'b0, 1'b0, pat[i]);
            if (glitch && i == 0) begin
                drive(1'b0, 1'b1, pat[i]);
                drive(1'b0, 1'b0, pat[i]);
            end
            drive(1'b1, 1'b0, pat[i]);
            // Released data line flips so a stale level never counts
            drive(1'b1, 1'b0, ~pat[i]);
        end
    endtask : send
endmodule : sprd_host

// ===== hdl/sprd_detect.sv
/*
 * Pin-pattern reset detector and ultra-deep power-down exit.
 * The link side runs on a clock made from the select pin alone;
 * the power state runs on the system clock. Assumes entry into
 * ultra-deep power-down is signalled by other logic as a level request.
 */

// Behaviour
// - A complete pin reset pattern takes the device out of ultra-deep sleep.
// - A power cycle (system reset) also leaves ultra-deep sleep.
// - Leaving ultra-deep sleep restores all registers to power-on values.
// - A detected pattern resets the device even without a power cycle.
// - Data sampled on four select rising edges must read 0101.
// - No serial output is driven before the first clock edge in a select.
// - Data is sampled on each select rising edge.
// - Internal reset starts only after the fourth pulse completes.
// - Any serial clock edge abandons detection, no reset; the code counts only edges while selected.
// - Select going low wakes the serial interface even in deep sleep.
// - In ultra-deep sleep every clocked command is ignored.
module sprd_detect
    import sprd_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic clock_enable,
    input  wire logic sel_clock,
    input  wire logic select_n,
    input  wire logic serial_clock,
    input  wire logic serial_in,
    input  wire logic udpd_request,
    output logic      device_reset,
    output logic      in_udpd,
    output logic      standby,
    output logic      command_enable,
    output logic      out_allowed,
    output logic      iface_awake
);
    import sprd_pkg::*;

    // ------------------------------------------------------------------
    // Link domain: sel_clock follows the select pin, so its rising edge
    // is the deselect edge that samples the data. Serial clock activity
    // inside a select window is caught by edge capture on that pin.
    // ------------------------------------------------------------------
    logic [3:0] hist;
    logic [3:0] next_hist;
    logic [2:0] count;
    logic [2:0] next_count;
    logic       hit_toggle;
    logic       next_hit_toggle;
    logic       sck_rise_seen;
    logic       sck_fall_seen;
    logic       sck_clear;
    logic       sck_dirty;

    // Serial clock edges within a select window, cleared while deselected
    always_ff @(posedge serial_clock or posedge sck_clear) begin
        if (sck_clear) begin
            sck_rise_seen <= 1'b0;
        end else begin
            sck_rise_seen <= 1'b1;
        end
    end

    always_ff @(negedge serial_clock or posedge sck_clear) begin
        if (sck_clear) begin
            sck_fall_seen <= 1'b0;
        end else begin
            sck_fall_seen <= 1'b1;
        end
    end

    assign sck_clear = select_n;
    assign sck_dirty = sck_rise_seen | sck_fall_seen;

    // Pattern history; the four-pulse window needs no buffering
    always_comb begin
        next_hist       = sprd_shift(hist, serial_in);
        next_count      = count + 3'h1;
        next_hit_toggle = hit_toggle;
        if (sck_dirty) begin
            next_hist  = 4'h0;
            next_count = COUNT_ZERO;
        end else if (count == (COUNT_FULL - 3'h1)) begin
            // Fourth pulse completes here, only now start the reset
            next_count = COUNT_ZERO;
            if (next_hist == RESET_PATTERN) begin
                next_hit_toggle = ~hit_toggle;
            end
        end
    end

    // Link state; the link clock only ticks during pulses
    always_ff @(posedge sel_clock or posedge rst) begin
        if (rst) begin
            hist       <= 4'h0;
            count      <= COUNT_ZERO;
            hit_toggle <= 1'b0;
        end else begin
            hist       <= next_hist;
            count      <= next_count;
            hit_toggle <= next_hit_toggle;
        end
    end

    // ------------------------------------------------------------------
    // Crossings into the system clock domain
    // ------------------------------------------------------------------
    logic hit_sync;
    logic sel_low_sync;
    logic sck_sync;

    sprd_sync u_hit (
        .clock    (clock),
        .rst      (rst),
        .enable   (clock_enable),
        .async_in (hit_toggle),
        .sync_out (hit_sync)
    );

    sprd_sync u_sel (
        .clock    (clock),
        .rst      (rst),
        .enable   (clock_enable),
        .async_in (~select_n),
        .sync_out (sel_low_sync)
    );

    sprd_sync u_sck (
        .clock    (clock),
        .rst      (rst),
        .enable   (clock_enable),
        .async_in (sck_dirty),
        .sync_out (sck_sync)
    );

    // ------------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------------
    sprd_pwr_type     state;
    sprd_pwr_type     next_state;
    logic [CNT_W-1:0] timer;
    logic [CNT_W-1:0] next_timer;
    logic             hit_prev;
    logic             hit_pulse;
    logic             next_device_reset;
    logic             next_in_udpd;
    logic             next_standby;
    logic             next_command_enable;
    logic             next_out_allowed;
    logic             next_iface_awake;

    assign hit_pulse = hit_sync ^ hit_prev;

    // Sequencing; pattern hit beats a sleep request in the same cycle
    always_comb begin
        next_state = state;
        next_timer = timer;
        case (state)
            PWR_STANDBY: begin
                if (hit_pulse) begin
                    next_state = PWR_RESET;
                    next_timer = CNT_W'(RESET_CYCLES);
                end else if (udpd_request) begin
                    next_state = PWR_UDPD;
                end
            end
            PWR_UDPD: begin
                if (hit_pulse) begin
                    next_state = PWR_RESET;
                    next_timer = CNT_W'(RESET_CYCLES);
                end
            end
            PWR_RESET: begin
                if (timer <= CNT_W'(1)) begin
                    next_state = PWR_WAKE;
                    next_timer = CNT_W'(WAKE_CYCLES);
                end else begin
                    next_timer = timer - CNT_W'(1);
                end
            end
            PWR_WAKE: begin
                if (hit_pulse) begin
                    next_state = PWR_RESET;
                    next_timer = CNT_W'(RESET_CYCLES);
                end else if (timer <= CNT_W'(1)) begin
                    next_state = PWR_STANDBY;
                end else begin
                    next_timer = timer - CNT_W'(1);
                end
            end
            default: begin
                next_state = PWR_STANDBY;
            end
        endcase
        // Registered outputs follow the next state; iface_awake follows the synced select alone
        next_device_reset   = (next_state == PWR_RESET);
        next_in_udpd        = (next_state == PWR_UDPD);
        next_standby        = (next_state == PWR_STANDBY);
        next_command_enable = (next_state == PWR_STANDBY);
        next_out_allowed    = sel_low_sync & sck_sync &
                              (next_state == PWR_STANDBY);
        next_iface_awake    = sel_low_sync;
    end

    // Power-on reset lands in the wake wait: a power cycle exits sleep
    always_ff @(posedge clock) begin
        if (rst) begin
            state          <= PWR_WAKE;
            timer          <= CNT_W'(WAKE_CYCLES);
            hit_prev       <= 1'b0;
            device_reset   <= 1'b1;
            in_udpd        <= 1'b0;
            standby        <= 1'b0;
            command_enable <= 1'b0;
            out_allowed    <= 1'b0;
            iface_awake    <= 1'b0;
        end else if (clock_enable) begin
            state          <= next_state;
            timer          <= next_timer;
            hit_prev       <= hit_sync;
            device_reset   <= next_device_reset;
            in_udpd        <= next_in_udpd;
            standby        <= next_standby;
            command_enable <= next_command_enable;
            out_allowed    <= next_out_allowed;
            iface_awake    <= next_iface_awake;
        end
    end
endmodule : sprd_detect

// ===== hdl/sprd_pkg.sv
/*
 * Constants and types for the pin-pattern reset detector.
 * Assumes a 125 MHz system clock and a serial link clocked by the
 * host's select pin, used as its own clock domain.
 */
package sprd_pkg;

    // ------------------------------------------------------------------
    // Pattern
    // ------------------------------------------------------------------
    localparam int          PAT_LEN         = 4;
    localparam logic [3:0]  RESET_PATTERN   = 4'h5;
    localparam logic [2:0]  COUNT_ZERO      = 3'h0;
    localparam logic [2:0]  COUNT_FULL      = 3'h4;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLOCK_MHZ       = 125;
    localparam int          WAKE_TIME_NS    = 75000;
    localparam int          WAKE_CYCLES     =
        (WAKE_TIME_NS * CLOCK_MHZ + 999) / 1000;
    localparam int          RESET_PULSE_NS  = 64;
    localparam int          RESET_CYCLES    =
        (RESET_PULSE_NS * CLOCK_MHZ + 999) / 1000;
    localparam int          CNT_W           = 14;

    // ------------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PWR_STANDBY,
        PWR_UDPD,
        PWR_RESET,
        PWR_WAKE
    } sprd_pwr_type;

    // Shift a new sampled data bit into the pattern history
    function automatic logic [3:0] sprd_shift(input logic [3:0] hist,
                                              input logic       bit_in);
        sprd_shift = {hist[2:0], bit_in};
    endfunction : sprd_shift

endpackage : sprd_pkg

// ===== hdl/sprd_sync.sv
/*
 * Two-flop synchroniser for a single level.
 * Assumes the destination clock and clock enable are those of the reader.
 */
module sprd_sync (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic async_in,
    output logic      sync_out
);
    logic first_stage;
    logic next_first;
    logic next_out;

    // ------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------
    always_comb begin
        next_first = first_stage;
        next_out   = sync_out;
        if (enable) begin
            next_first = async_in;
            next_out   = first_stage;   // Only reader of the first stage
        end
    end

    // Registers
    always_ff @(posedge clock) begin
        if (rst) begin
            first_stage <= 1'b0;
            sync_out    <= 1'b0;
        end else begin
            first_stage <= next_first;
            sync_out    <= next_out;
        end
    end
endmodule : sprd_sync
